//--- dv/sysctl_monitor.sv
// Port checker for the system control register bank
module sysctl_monitor #(
   parameter WAIT_CNT_W = 2
) (
   input logic core_clk, // Clock
   input logic rst_n, // Reset
   input logic hsel, // Select
   input logic [1:0] htrans, // Transfer type
   input logic hwrite, // Write
   input logic hready, // Bus ready
   input logic hreadyout, // Slave ready
   input logic hresp, // Response
   input logic [31:0] hrdata, // Read data
   input logic extAccessStart, // Access start
   input logic waitStateCycle, // Wait cycle
   input logic [1:0] waitModeSel, // Wait mode
   input logic [WAIT_CNT_W-1:0] waitCount, // Wait count
   input logic onchipRamOn, // RAM enable
   input logic sleepInsn, // Sleep request
   input logic sleepEnter, // Sleep pulse
   input logic standbyEnter, // Standby pulse
   input logic standbySelect, // Standby bit
   input logic wdtOverflow, // Overflow
   input logic internalReset, // Internal reset
   input logic resetPinOe, // Reset drive
   input logic watchdogResetFlag // Flag
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic rdTaken;
   logic wrTaken;
   assign rdTaken = hsel && hready && htrans[1] && !hwrite;
   assign wrTaken = hsel && hready && htrans[1] && hwrite;
   read_wait_a: assert property (rdTaken |=> !hreadyout ##1 hreadyout)
      else $error("read data phase length wrong");
   write_nowait_a: assert property (wrTaken |=> hreadyout) else $error("write stalled");
   resp_okay_a: assert property (hresp == 1'b0) else $error("response not okay");
   upper_zero_a: assert property (hrdata[31:8] == 24'h0) else $error("upper bits set");
   sleep_pulse_a: assert property (
      sleepInsn && !standbySelect |=> sleepEnter && !standbyEnter) else $error("no sleep");
   standby_pulse_a: assert property (
      sleepInsn && standbySelect |=> standbyEnter && !sleepEnter) else $error("no standby");
   reset_out_a: assert property (!internalReset |-> !resetPinOe) else $error("reset driven");
   flag_set_a: assert property (wdtOverflow |=> watchdogResetFlag) else $error("flag not set");
   wait_none_a: assert property (
      extAccessStart && waitModeSel == 2'h0 && waitCount == 0 |=> !waitStateCycle [*3])
      else $error("wait inserted at zero count");
   wait_count_a: assert property (
      extAccessStart && waitModeSel == 2'h0 && waitCount == 2
      |=> waitStateCycle [*2] ##1 !waitStateCycle) else $error("wait count wrong");
   ram_write_a: assert property ($changed(onchipRamOn) |-> $past(wrTaken, 2))
      else $error("ram enable moved without write");
   cover property (rdTaken);
   cover property (sleepInsn && standbySelect);
   cover property (extAccessStart && waitCount == 2);
   cover property (waitStateCycle && waitModeSel == 2'h3);
endmodule // sysctl_monitor

//--- dv/tb_top.sv
// Self-checking bench for the system control register bank
`include "sysctl_defines.vh"
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   localparam WAIT_CNT_W = 2;
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic extAccessStart = 1'b0;
   logic waitPin_n = 1'b1;
   logic sleepInsn = 1'b0;
   logic wdtOverflow = 1'b0;
   logic internalReset = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] rdat;
   wire hready, hresp, waitStateCycle, onchipRamOn, sleepEnter, standbyEnter, standbySelect;
   wire resetPinOe, resetPinOut, watchdogResetFlag;
   wire [1:0] waitModeSel;
   wire [WAIT_CNT_W-1:0] waitCount;
   wire [31:0] hrdata;
   int miscompares = 0;
   int n_tests = 0;
   always #5 core_clk = ~core_clk;
   system_control_regs #(.WAIT_CNT_W(WAIT_CNT_W)) system_control_regs_i (
      .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
      .hresp(hresp), .hrdata(hrdata), .modePin2(1'b1), .modePin1(1'b0), .modePin0(1'b1),
      .extAccessStart(extAccessStart), .waitPin_n(waitPin_n), .waitStateCycle(waitStateCycle),
      .waitModeSel(waitModeSel), .waitCount(waitCount), .onchipRamOn(onchipRamOn),
      .sleepInsn(sleepInsn), .sleepEnter(sleepEnter), .standbyEnter(standbyEnter),
      .standbySelect(standbySelect), .wdtOverflow(wdtOverflow), .internalReset(internalReset),
      .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .watchdogResetFlag(watchdogResetFlag));
   task report_and_stop;
      if (miscompares == 0 && n_tests > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task wait_ready;
      int k;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (hready !== 1'b1 && k < 50);
      if (hready !== 1'b1) begin
         miscompares++;
         report_and_stop;
      end
   endtask
   task bus(input logic w, input logic [15:0] idx, input logic [7:0] wd);
      @(posedge core_clk);
      hsel <= 1'b1;
      haddr <= {14'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      wait_ready;
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= {24'h0, wd};
      wait_ready;
      rdat = hrdata;
   endtask
   task rd(input logic [15:0] idx, input logic [7:0] exp, input string nm);
      bus(1'b0, idx, 8'h0);
      chk(nm, {24'h0, exp}, rdat);
   endtask
   task do_reset;
      rst_n <= 1'b0;
      tick(10);
      rst_n <= 1'b1;
      tick(4);
   endtask
   task t_reset_values;
      rd(`IDX_BUS_WAIT_CONTROL, 8'hf3, "wait ctrl");
      rd(`IDX_ONCHIP_MEMORY_ENABLE, 8'hff, "ram enable");
      rd(`IDX_OPERATING_MODE_READBACK, 8'hc5, "mode");
      rd(`IDX_LOW_POWER_SELECT, 8'h7f, "low power");
      rd(`IDX_WATCHDOG_RESET_STATUS, 8'h3f, "wdt status");
      rd(16'hff14, 8'h00, "unmapped");
      bus(1'b1, `IDX_OPERATING_MODE_READBACK, 8'h00);
      rd(`IDX_OPERATING_MODE_READBACK, 8'hc5, "mode kept");
      bus(1'b1, `IDX_ONCHIP_MEMORY_ENABLE, 8'h00);
      rd(`IDX_ONCHIP_MEMORY_ENABLE, 8'h7f, "ram off");
      chk("onchipRamOn", 32'h0, onchipRamOn);
      bus(1'b1, `IDX_ONCHIP_MEMORY_ENABLE, 8'hff);
      tick(1);
      chk("onchipRamOn", 32'h1, onchipRamOn);
   endtask
   task wait_run(input logic [7:0] cfg, input int n);
      int cnt;
      bus(1'b1, `IDX_BUS_WAIT_CONTROL, cfg);
      rd(`IDX_BUS_WAIT_CONTROL, cfg | 8'hf0, "wait ctrl rw");
      chk("waitModeSel", cfg[3:2], waitModeSel);
      chk("waitCount", cfg[1:0], waitCount);
      cnt = 0;
      @(posedge core_clk);
      extAccessStart <= 1'b1;
      @(posedge core_clk);
      extAccessStart <= 1'b0;
      repeat (6) begin
         @(posedge core_clk);
         cnt += (waitStateCycle === 1'b1);
      end
      chk("wait cycles", n, cnt);
   endtask
   task wait_pin(input logic [7:0] cfg);
      waitPin_n <= 1'b0;
      wait_run(cfg, 6);
      waitPin_n <= 1'b1;
      tick(4);
      chk("wait released", 32'h0, waitStateCycle);
   endtask
   task sleep_run(input logic s);
      bus(1'b1, `IDX_LOW_POWER_SELECT, {s, 7'h0});
      rd(`IDX_LOW_POWER_SELECT, {s, 7'h7f}, "low power rw");
      chk("standbySelect", s, standbySelect);
      @(posedge core_clk);
      sleepInsn <= 1'b1;
      @(posedge core_clk);
      sleepInsn <= 1'b0;
      @(posedge core_clk);
      chk("sleepEnter", !s, sleepEnter);
      chk("standbyEnter", s, standbyEnter);
   endtask
   task overflow;
      @(posedge core_clk);
      wdtOverflow <= 1'b1;
      @(posedge core_clk);
      wdtOverflow <= 1'b0;
   endtask
   task t_watchdog;
      overflow;
      rd(`IDX_WATCHDOG_RESET_STATUS, 8'hbf, "flag set");
      bus(1'b1, `IDX_WATCHDOG_RESET_STATUS, 8'h80);
      rd(`IDX_WATCHDOG_RESET_STATUS, 8'hbf, "flag kept");
      internalReset <= 1'b1;
      tick(1);
      chk("resetPinOe off", 32'h0, resetPinOe);
      bus(1'b1, `IDX_WATCHDOG_RESET_STATUS, 8'h40);
      rd(`IDX_WATCHDOG_RESET_STATUS, 8'h7f, "flag cleared");
      chk("resetPinOe on", 32'h1, resetPinOe);
      chk("resetPinOut", 32'h0, resetPinOut);
      internalReset <= 1'b0;
      tick(1);
      chk("resetPinOe idle", 32'h0, resetPinOe);
      overflow;
      tick(1);
      chk("flag before pin", 32'h1, watchdogResetFlag);
      do_reset;
      chk("flag after pin", 32'h0, watchdogResetFlag);
      rd(`IDX_WATCHDOG_RESET_STATUS, 8'h3f, "status after pin");
   endtask
   initial begin
      do_reset;
      t_reset_values;
      wait_run(8'h02, 2);
      wait_run(8'h00, 0);
      wait_run(8'h03, 3);
      wait_run(8'h0f, 0);
      wait_pin(8'h0c);
      wait_pin(8'h05);
      sleep_run(1'b0);
      sleep_run(1'b1);
      t_watchdog;
      report_and_stop;
   end
endmodule // tb_top
bind system_control_regs sysctl_monitor #(.WAIT_CNT_W(WAIT_CNT_W)) sysctl_monitor_i (
   .core_clk(core_clk), .rst_n(rst_n), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .extAccessStart(extAccessStart), .waitStateCycle(waitStateCycle), .waitModeSel(waitModeSel),
   .waitCount(waitCount), .onchipRamOn(onchipRamOn), .sleepInsn(sleepInsn),
   .sleepEnter(sleepEnter), .standbyEnter(standbyEnter), .standbySelect(standbySelect),
   .wdtOverflow(wdtOverflow), .internalReset(internalReset), .resetPinOe(resetPinOe),
   .watchdogResetFlag(watchdogResetFlag));

//--- logic/sync_2ff.v
// Two-flop synchroniser for asynchronous level inputs
module sync_2ff #(
   parameter WIDTH = 1,
   parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
   input wire core_clk, // System clock
   input wire rst_n, // Asynchronous reset, active low
   input wire [WIDTH-1:0] asyncIn, // Level from outside the clock domain
   output wire [WIDTH-1:0] syncOut // Synchronised level
);
   reg [WIDTH-1:0] stage1_q;
   reg [WIDTH-1:0] stage2_q;

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         stage1_q <= RESET_VAL;
         stage2_q <= RESET_VAL;
      end else begin
         stage1_q <= asyncIn;
         stage2_q <= stage1_q;
      end
   end

   assign syncOut = stage2_q;
endmodule // sync_2ff

//--- logic/sysctl_defines.vh
// Offsets, field positions, reset values and codes of the system control bank
`ifndef SYSCTL_DEFINES_VH
`define SYSCTL_DEFINES_VH

// Register indices; byte address is four times the index
`define IDX_BUS_WAIT_CONTROL 16'hff10
`define IDX_ONCHIP_MEMORY_ENABLE 16'hff11
`define IDX_OPERATING_MODE_READBACK 16'hff12
`define IDX_LOW_POWER_SELECT 16'hff13
`define IDX_WATCHDOG_RESET_STATUS 16'hff15

// Bus address slicing
`define ADDR_IDX_HI 17
`define ADDR_IDX_LO 2
`define ADDR_TOP_HI 31
`define ADDR_TOP_LO 18
`define ADDR_TOP_ZERO 14'h0000
`define ADDR_BYTE_ZERO 2'h0

// Bus codes
`define HSIZE_WORD 3'h2
`define HRESP_OKAY 1'b0
`define HTRANS_ACTIVE_BIT 1

// Field positions
`define WCR_COUNT_HI 1
`define WCR_COUNT_LO 0
`define WCR_MODE_HI 3
`define WCR_MODE_LO 2
`define ONCHIP_MEMORY_ENABLE_ENABLE_BIT 7
`define LOW_POWER_SELECT_STANDBY_BIT 7
`define WATCHDOG_RESET_STATUS_FLAG_BIT 7
`define WATCHDOG_RESET_STATUS_OE_BIT 6

// Reset values and fixed bits
`define WCR_RESET 8'hf3
`define WCR_FIXED 8'hf0
`define ONCHIP_MEMORY_ENABLE_RESET 8'hff
`define ONCHIP_MEMORY_ENABLE_FIXED 8'h7f
`define OPERATING_MODE_READBACK_FIXED 8'hc0
`define LOW_POWER_SELECT_RESET 8'h7f
`define LOW_POWER_SELECT_FIXED 8'h7f
`define WATCHDOG_RESET_STATUS_RESET 8'h3f
`define WATCHDOG_RESET_STATUS_FIXED 8'h3f
`define WAIT_COUNT_RESET 2'h3
`define WAIT_MODE_RESET 2'h0
`define RAM_ON_RESET 1'b1

// Wait mode codes
`define WAIT_MODE_PROG 2'h0
`define WAIT_MODE_PIN_AUTO 2'h3

// Cycles from reset release until mode pins are through the synchroniser
`define MODE_CAPTURE_DELAY 2'h2

`endif

//--- logic/system_control_regs.v
// System control register bank on an AHB-Lite slave port
// Behaviour
// - Two-bit wait count sets external wait cycles; zero inserts none.
// - Two-bit wait mode select; both bits one selects pin auto-wait.
// - Programmable wait mode inserts wait-count cycles on external accesses.
// - Mode pins captured into read-only bits 2..0 at reset.
// - Standby select zero: sleep instruction enters sleep; resets to zero.
// - Standby select one: sleep instruction enters software standby.
// - Watchdog overflow with reset sets watchdog reset flag bit 7.
// - Flag cleared by software or by low reset pin.
// - Writing zero to bit 7 clears flag; writing one leaves it.
//
// The implementer's own choice: the AHB-Lite interface to the registers.
`include "sysctl_defines.vh"
module system_control_regs #(
   parameter WAIT_CNT_W = 2
) (
   input wire core_clk, // System clock, 100 MHz
   input wire rst_n, // Reset pin, asynchronous, active low
   input wire hsel, // AHB slave select
   input wire [31:0] haddr, // AHB address
   input wire [1:0] htrans, // AHB transfer type
   input wire hwrite, // AHB write
   input wire [2:0] hsize, // AHB transfer size
   input wire [31:0] hwdata, // AHB write data
   input wire hready, // AHB bus ready
   output wire hreadyout, // AHB slave ready
   output wire hresp, // AHB response, always OKAY
   output reg [31:0] hrdata, // AHB read data
   input wire modePin2, // Mode pin 2, asynchronous
   input wire modePin1, // Mode pin 1, asynchronous
   input wire modePin0, // Mode pin 0, asynchronous
   input wire extAccessStart, // Pulse, external bus access begins
   input wire waitPin_n, // External wait pin, asynchronous, active low
   output wire waitStateCycle, // High during inserted wait cycles
   output wire [1:0] waitModeSel, // Current wait mode select
   output wire [WAIT_CNT_W-1:0] waitCount, // Current wait count
   output wire onchipRamOn, // On-chip RAM enable
   input wire sleepInsn, // Pulse, sleep instruction executed
   output reg sleepEnter, // Pulse, enter sleep mode
   output reg standbyEnter, // Pulse, enter software standby mode
   output wire standbySelect, // Current standby select bit
   input wire wdtOverflow, // Pulse, watchdog counter overflow with reset
   input wire internalReset, // Internally generated reset, active high
   output wire resetPinOut, // Reset pin output value (open drain, low)
   output wire resetPinOe, // Reset pin output enable, high drives low
   output wire watchdogResetFlag // Current watchdog reset flag
);
   // Stored fields
   reg [1:0] waitModeSel_q;
   reg [WAIT_CNT_W-1:0] waitCount_q;
   reg onchipRamOn_q;
   reg [2:0] modeLatch_q;
   reg modeCaptured_q;
   reg [1:0] captureCnt_q;
   reg standbySelect_q;
   reg watchdogResetFlag_q;
   reg resetDriveOutEn_q;

   // Next values of the stored fields
   reg [1:0] waitModeSel_d;
   reg [WAIT_CNT_W-1:0] waitCount_d;
   reg onchipRamOn_d;
   reg [2:0] modeLatch_d;
   reg modeCaptured_d;
   reg [1:0] captureCnt_d;
   reg standbySelect_d;
   reg watchdogResetFlag_d;
   reg resetDriveOutEn_d;
   reg sleepEnter_d;
   reg standbyEnter_d;

   // Bus pipeline
   reg wrPend_q;
   reg rdPend_q;
   reg [15:0] addrIdx_q;
   reg addrValid_q;
   reg wrPend_d;
   reg rdPend_d;
   reg [15:0] addrIdx_d;
   reg addrValid_d;
   reg [31:0] hrdata_d;

   wire [2:0] modePinSync;
   wire waitPinSync_n;
   wire accessPhase;
   wire addrOk;
   wire sizeOk;
   wire hitWait;
   wire hitRam;
   wire hitMode;
   wire hitLowPower;
   wire hitWdt;
   wire wrWait;
   wire wrRam;
   wire wrLowPower;
   wire wrWdt;
   wire flagClearReq;
   reg [7:0] readMux;

   sync_2ff #(
      .WIDTH(3),
      .RESET_VAL(3'h0)
   ) u_modeSync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .asyncIn({modePin2, modePin1, modePin0}),
      .syncOut(modePinSync)
   );

   sync_2ff #(
      .WIDTH(1),
      .RESET_VAL(1'b1)
   ) u_waitSync (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .asyncIn(waitPin_n),
      .syncOut(waitPinSync_n)
   );

   // Address phase decode
   assign accessPhase = hsel && hready && htrans[`HTRANS_ACTIVE_BIT];
   assign addrOk = (haddr[`ADDR_TOP_HI:`ADDR_TOP_LO] == `ADDR_TOP_ZERO) &&
                   (haddr[1:0] == `ADDR_BYTE_ZERO);
   assign sizeOk = (hsize == `HSIZE_WORD);

   // Reads take one wait state so hrdata comes straight from a flop
   assign hreadyout = !rdPend_q;
   assign hresp = `HRESP_OKAY;

   always @* begin
      wrPend_d = 1'b0;
      rdPend_d = 1'b0;
      addrIdx_d = addrIdx_q;
      addrValid_d = addrValid_q;
      if (accessPhase) begin
         wrPend_d = hwrite;
         rdPend_d = !hwrite;
         addrIdx_d = haddr[`ADDR_IDX_HI:`ADDR_IDX_LO];
         addrValid_d = addrOk && sizeOk;
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wrPend_q <= 1'b0;
         rdPend_q <= 1'b0;
         addrIdx_q <= 16'h0000;
         addrValid_q <= 1'b0;
      end else begin
         wrPend_q <= wrPend_d;
         rdPend_q <= rdPend_d;
         addrIdx_q <= addrIdx_d;
         addrValid_q <= addrValid_d;
      end
   end

   assign hitWait = addrValid_q && (addrIdx_q == `IDX_BUS_WAIT_CONTROL);
   assign hitRam = addrValid_q && (addrIdx_q == `IDX_ONCHIP_MEMORY_ENABLE);
   assign hitMode = addrValid_q && (addrIdx_q == `IDX_OPERATING_MODE_READBACK);
   assign hitLowPower = addrValid_q && (addrIdx_q == `IDX_LOW_POWER_SELECT);
   assign hitWdt = addrValid_q && (addrIdx_q == `IDX_WATCHDOG_RESET_STATUS);

   assign wrWait = wrPend_q && hitWait;
   assign wrRam = wrPend_q && hitRam;
   assign wrLowPower = wrPend_q && hitLowPower;
   assign wrWdt = wrPend_q && hitWdt;

   // Wait-state control fields
   always @* begin
      waitCount_d = waitCount_q;
      waitModeSel_d = waitModeSel_q;
      if (wrWait) begin
         waitCount_d = hwdata[`WCR_COUNT_HI:`WCR_COUNT_LO];
         waitModeSel_d = hwdata[`WCR_MODE_HI:`WCR_MODE_LO];
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         waitCount_q <= `WAIT_COUNT_RESET;
         waitModeSel_q <= `WAIT_MODE_RESET;
      end else begin
         waitCount_q <= waitCount_d;
         waitModeSel_q <= waitModeSel_d;
      end
   end

   // On-chip RAM enable
   always @* begin
      onchipRamOn_d = onchipRamOn_q;
      if (wrRam) begin
         onchipRamOn_d = hwdata[`ONCHIP_MEMORY_ENABLE_ENABLE_BIT];
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         onchipRamOn_q <= `RAM_ON_RESET;
      end else begin
         onchipRamOn_q <= onchipRamOn_d;
      end
   end

   // Mode pins sampled once, after they have passed the synchroniser
   always @* begin
      modeLatch_d = modeLatch_q;
      modeCaptured_d = modeCaptured_q;
      captureCnt_d = captureCnt_q;
      if (!modeCaptured_q) begin
         if (captureCnt_q == `MODE_CAPTURE_DELAY) begin
            modeLatch_d = modePinSync;
            modeCaptured_d = 1'b1;
         end else begin
            captureCnt_d = captureCnt_q + 2'h1;
         end
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         modeLatch_q <= 3'h0;
         modeCaptured_q <= 1'b0;
         captureCnt_q <= 2'h0;
      end else begin
         modeLatch_q <= modeLatch_d;
         modeCaptured_q <= modeCaptured_d;
         captureCnt_q <= captureCnt_d;
      end
   end

   // Standby select
   always @* begin
      standbySelect_d = standbySelect_q;
      if (wrLowPower) begin
         standbySelect_d = hwdata[`LOW_POWER_SELECT_STANDBY_BIT];
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         standbySelect_q <= 1'b0;
      end else begin
         standbySelect_q <= standbySelect_d;
      end
   end

   // Sleep instruction steering
   always @* begin
      sleepEnter_d = sleepInsn && !standbySelect_q;
      standbyEnter_d = sleepInsn && standbySelect_q;
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         sleepEnter <= 1'b0;
         standbyEnter <= 1'b0;
      end else begin
         sleepEnter <= sleepEnter_d;
         standbyEnter <= standbyEnter_d;
      end
   end

   // Watchdog reset flag; reset pin low clears it through rst_n
   assign flagClearReq = wrWdt && !hwdata[`WATCHDOG_RESET_STATUS_FLAG_BIT];

   always @* begin
      watchdogResetFlag_d = watchdogResetFlag_q;
      resetDriveOutEn_d = resetDriveOutEn_q;
      // A new overflow wins over a clear in the same cycle
      if (wdtOverflow) begin
         watchdogResetFlag_d = 1'b1;
      end else if (flagClearReq) begin
         watchdogResetFlag_d = 1'b0;
      end
      if (wrWdt) begin
         resetDriveOutEn_d = hwdata[`WATCHDOG_RESET_STATUS_OE_BIT];
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         watchdogResetFlag_q <= 1'b0;
         resetDriveOutEn_q <= 1'b0;
      end else begin
         watchdogResetFlag_q <= watchdogResetFlag_d;
         resetDriveOutEn_q <= resetDriveOutEn_d;
      end
   end

   // Open-drain reset pin: pulled low only while enabled
   assign resetPinOut = 1'b0;
   assign resetPinOe = internalReset && resetDriveOutEn_q;

   // Read data; fixed bits come from constants
   always @* begin
      readMux = 8'h00;
      if (hitWait) begin
         readMux = `WCR_FIXED;
         readMux[`WCR_MODE_HI:`WCR_MODE_LO] = waitModeSel_q;
         readMux[`WCR_COUNT_HI:`WCR_COUNT_LO] = waitCount_q;
      end else if (hitRam) begin
         readMux = `ONCHIP_MEMORY_ENABLE_FIXED;
         readMux[`ONCHIP_MEMORY_ENABLE_ENABLE_BIT] = onchipRamOn_q;
      end else if (hitMode) begin
         readMux = {`OPERATING_MODE_READBACK_FIXED} | {5'h00, modeLatch_q};
      end else if (hitLowPower) begin
         readMux = `LOW_POWER_SELECT_FIXED;
         readMux[`LOW_POWER_SELECT_STANDBY_BIT] = standbySelect_q;
      end else if (hitWdt) begin
         readMux = `WATCHDOG_RESET_STATUS_FIXED;
         readMux[`WATCHDOG_RESET_STATUS_FLAG_BIT] = watchdogResetFlag_q;
         readMux[`WATCHDOG_RESET_STATUS_OE_BIT] = resetDriveOutEn_q;
      end
   end

   always @* begin
      hrdata_d = hrdata;
      if (rdPend_q) begin
         hrdata_d = {24'h000000, readMux};
      end
   end

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         hrdata <= 32'h00000000;
      end else begin
         hrdata <= hrdata_d;
      end
   end

   wait_state_gen #(
      .CNT_W(WAIT_CNT_W)
   ) u_waitGen (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .accessStart(extAccessStart),
      .waitMode(waitModeSel_q),
      .waitCount(waitCount_q),
      .waitPinReq(!waitPinSync_n),
      .waitActive(waitStateCycle)
   );

   assign waitModeSel = waitModeSel_q;
   assign waitCount = waitCount_q;
   assign onchipRamOn = onchipRamOn_q;
   assign standbySelect = standbySelect_q;
   assign watchdogResetFlag = watchdogResetFlag_q;
endmodule // system_control_regs

//--- logic/wait_state_gen.v
// External access wait-state generator
`include "sysctl_defines.vh"
module wait_state_gen #(
   parameter CNT_W = 2
) (
   input wire core_clk, // System clock
   input wire rst_n, // Asynchronous reset, active low
   input wire accessStart, // One-cycle pulse, external access begins
   input wire [1:0] waitMode, // Wait mode select field
   input wire [CNT_W-1:0] waitCount, // Wait count field
   input wire waitPinReq, // Synchronised wait pin, high = hold
   output wire waitActive // High during each inserted wait cycle
);
   reg [CNT_W-1:0] cnt_q;
   reg busy_q;
   wire pinMode;
   wire pinHold;

   assign pinMode = (waitMode != `WAIT_MODE_PROG);
   assign pinHold = pinMode && waitPinReq;
   assign waitActive = busy_q && ((cnt_q != {CNT_W{1'b0}}) || pinHold);

   always @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= {CNT_W{1'b0}};
         busy_q <= 1'b0;
      end else if (accessStart) begin
         busy_q <= 1'b1;
         // Auto mode waits on the pin only
         if (waitMode == `WAIT_MODE_PIN_AUTO) begin
            cnt_q <= {CNT_W{1'b0}};
         end else begin
            cnt_q <= waitCount;
         end
      end else if (busy_q) begin
         if (cnt_q != {CNT_W{1'b0}}) begin
            cnt_q <= cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
         end else if (!pinHold) begin
            busy_q <= 1'b0;
         end
      end
   end
endmodule // wait_state_gen
